// *** inc/banked_defs.svh ***
// constants for the banked memory map decoder
// assumes inclusion by bare name from interface and design files
`ifndef BANKED_DEFS_SVH
`define BANKED_DEFS_SVH
`define PC_RESET_VEC 13'h0000
`define PC_IRQ_VEC 13'h0004
`define PC_ONE 13'h0001
`define PC_SMALL_MASK 13'h0FFF
`define OFF_INDIRECT 7'h00
`define OFF_PCL 7'h02
`define OFF_STATUS 7'h03
`define OFF_FSR 7'h04
`define OFF_PROGRAM_COUNTER_UPPER_LATCH 7'h0A
`define OFF_GPR_LO 7'h20
`define OFF_GPR_HI 7'h6F
`define OFF_COMMON_LO 7'h70
`define OFF_B3_GPR_LO 7'h10
`define RAM_BASE_B1 9'h060
`define RAM_BASE_B2 9'h0B0
`define RAM_BASE_B3 9'h100
`define RAM_DEPTH 352
`define RAM_AW 9
`define STATUS_RESET 8'h00
`define FSR_RESET 8'h00
`define PROGRAM_COUNTER_UPPER_LATCH_RESET 8'h00
`define DATA_ZERO 8'h00
`define STATUS_IRP_BIT 7
`define STATUS_BANK_HI 6
`define STATUS_BANK_LO 5
`define PROGRAM_COUNTER_UPPER_LATCH_PCL_HI 4
`define PROGRAM_COUNTER_UPPER_LATCH_JMP_HI 4
`define PROGRAM_COUNTER_UPPER_LATCH_JMP_LO 3
`endif

// *** inc/banked_pkg.sv ***
// types used by the decoder for its target decode and data addresses
// assumes banked_defs.svh is on the include path
package banked_pkg;
  typedef enum logic [2:0] {
    TGT_NONE,
    TGT_RAM,
    TGT_PCL,
    TGT_STATUS,
    TGT_FSR,
    TGT_PROGRAM_COUNTER_UPPER_LATCH
  } target_e;
  typedef logic [8:0] data_addr_t;
endpackage : banked_pkg

// *** inc/ram_if.sv ***
// carrier between the decoder and its general purpose ram
// assumes one clock shared by both ends
`timescale 1ns/10ps
`default_nettype none
`include "banked_defs.svh"
interface ram_if;
  logic en;
  logic we;
  logic [`RAM_AW-1:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport ctrl (output en, output we, output addr, output wdata, input rdata);
  modport mem (input en, input we, input addr, input wdata, output rdata);
endinterface : ram_if
`default_nettype wire

// *** hw/gp_ram.sv ***
// general purpose byte storage, read data registered
// assumes the decoder only presents in-range addresses
`timescale 1ns/10ps
`default_nettype none
`include "banked_defs.svh"
module gp_ram (
  input wire logic clk_in,
  ram_if.mem port
);
  logic [7:0] mem_q [0:`RAM_DEPTH-1];
  logic [7:0] rdata_q;
  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  // no reset on the array: it is plain static ram
  always_ff @(posedge clk_in) begin
    if (port.en && port.we) begin
      mem_q[port.addr] <= port.wdata;
    end
    if (port.en) begin
      rdata_q <= mem_q[port.addr];
    end
  end
  assign port.rdata = rdata_q;
endmodule : gp_ram
`default_nettype wire

// *** hw/banked_memory_map_decoder.sv ***
// program counter and banked data address decoder of an 8-bit core
// assumes the core's fetch and data logic run on clk_in and hold one access per cycle
`timescale 1ns/10ps
`default_nettype none
`include "banked_defs.svh"
// Notes on behaviour
// - thirteen-bit program counter addresses fourteen-bit program words
// - program space is 0000h-0FFFh small, 0000h-1FFFh large
// - small variant wraps addresses above 4K into the first 4K
// - fetching starts at 0000h after reset
// - taking an interrupt loads the counter with 0004h
// - bank bits 00,01,10,11 select banks 0 to 3
// - each bank has 128 offsets, 00h to 7Fh
// - low offsets are special registers, higher offsets general ram
// - core special registers mirror into every bank, same storage
// - general ram totals 256 or 352 bytes by variant
// - every register reachable directly or via file select pointer
// - unimplemented locations read as zero
// - offset 00h has no storage; it redirects through the pointer
module banked_memory_map_decoder #(
  parameter bit LARGE_PROG = 1'b1,
  parameter bit BANK3_RAM = 1'b1
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic pc_advance_in,
  input wire logic pc_jump_in,
  input wire logic [10:0] pc_jump_addr_in,
  input wire logic irq_take_in,
  input wire logic acc_valid_in,
  input wire logic acc_write_in,
  input wire logic [6:0] acc_offset_in,
  input wire logic [7:0] acc_wdata_in,
  output logic [12:0] prog_addr_out,
  output logic [7:0] rdata_out,
  output logic rvalid_out,
  output logic [1:0] bank_out
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [12:0] pc_q, pc_d;
  logic [7:0] status_q, status_d;
  logic [7:0] fsr_q, fsr_d;
  logic [7:0] program_counter_upper_latch_q, program_counter_upper_latch_d;
  logic rd_s1_q, rd_s1_d;
  logic ram_s1_q, ram_s1_d;
  logic [7:0] reg_s1_q, reg_s1_d;
  logic [7:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;
  banked_pkg::data_addr_t addr;
  banked_pkg::target_e tgt;
  logic [`RAM_AW-1:0] ram_idx;
  logic [6:0] off;
  logic [1:0] bank;
  logic wr;
  ram_if ram ();
  gp_ram u_ram (
    .clk_in(clk_in),
    .port(ram.mem)
  );
  // ------------------------------------------------------------
  // address formation and decode
  // ------------------------------------------------------------
  always_comb begin
    if (acc_offset_in == `OFF_INDIRECT) begin
      addr = {status_q[`STATUS_IRP_BIT], fsr_q};
    end else begin
      addr = {status_q[`STATUS_BANK_HI:`STATUS_BANK_LO], acc_offset_in};
    end
    off = addr[6:0];
    bank = addr[8:7];
    tgt = banked_pkg::TGT_NONE;
    ram_idx = '0;
    // a pointer that itself names 00h reaches nothing, so it reads zero
    if (off == `OFF_PCL) begin
      tgt = banked_pkg::TGT_PCL;
    end else if (off == `OFF_STATUS) begin
      tgt = banked_pkg::TGT_STATUS;
    end else if (off == `OFF_FSR) begin
      tgt = banked_pkg::TGT_FSR;
    end else if (off == `OFF_PROGRAM_COUNTER_UPPER_LATCH) begin
      tgt = banked_pkg::TGT_PROGRAM_COUNTER_UPPER_LATCH;
    end else if (off >= `OFF_COMMON_LO) begin
      tgt = banked_pkg::TGT_RAM;
      ram_idx = {2'b00, off - `OFF_GPR_LO};
    end else if (off >= `OFF_GPR_LO && bank != 2'b11) begin
      tgt = banked_pkg::TGT_RAM;
      if (bank == 2'b00) begin
        ram_idx = {2'b00, off - `OFF_GPR_LO};
      end else if (bank == 2'b01) begin
        ram_idx = `RAM_BASE_B1 + {2'b00, off - `OFF_GPR_LO};
      end else begin
        ram_idx = `RAM_BASE_B2 + {2'b00, off - `OFF_GPR_LO};
      end
    end else if (BANK3_RAM && bank == 2'b11 && off >= `OFF_B3_GPR_LO) begin
      tgt = banked_pkg::TGT_RAM;
      ram_idx = `RAM_BASE_B3 + {2'b00, off - `OFF_B3_GPR_LO};
    end
  end
  assign wr = acc_valid_in && acc_write_in;
  assign ram.en = acc_valid_in && (tgt == banked_pkg::TGT_RAM);
  assign ram.we = acc_write_in;
  assign ram.addr = ram_idx;
  assign ram.wdata = acc_wdata_in;
  // ------------------------------------------------------------
  // core registers and program counter
  // ------------------------------------------------------------
  always_comb begin
    status_d = status_q;
    fsr_d = fsr_q;
    program_counter_upper_latch_d = program_counter_upper_latch_q;
    pc_d = pc_q;
    if (wr && tgt == banked_pkg::TGT_STATUS) begin
      status_d = acc_wdata_in;
    end
    if (wr && tgt == banked_pkg::TGT_FSR) begin
      fsr_d = acc_wdata_in;
    end
    if (wr && tgt == banked_pkg::TGT_PROGRAM_COUNTER_UPPER_LATCH) begin
      program_counter_upper_latch_d = acc_wdata_in;
    end
    if (irq_take_in) begin
      pc_d = `PC_IRQ_VEC;
    end else if (wr && tgt == banked_pkg::TGT_PCL) begin
      pc_d = {program_counter_upper_latch_q[`PROGRAM_COUNTER_UPPER_LATCH_PCL_HI:0], acc_wdata_in};
    end else if (pc_jump_in) begin
      pc_d = {program_counter_upper_latch_q[`PROGRAM_COUNTER_UPPER_LATCH_JMP_HI:`PROGRAM_COUNTER_UPPER_LATCH_JMP_LO], pc_jump_addr_in};
    end else if (pc_advance_in) begin
      pc_d = pc_q + `PC_ONE;
    end
    if (!LARGE_PROG) begin
      pc_d = pc_d & `PC_SMALL_MASK;
    end
  end
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pc_q <= `PC_RESET_VEC;
      status_q <= `STATUS_RESET;
      fsr_q <= `FSR_RESET;
      program_counter_upper_latch_q <= `PROGRAM_COUNTER_UPPER_LATCH_RESET;
    end else begin
      pc_q <= pc_d;
      status_q <= status_d;
      fsr_q <= fsr_d;
      program_counter_upper_latch_q <= program_counter_upper_latch_d;
    end
  end
  // ------------------------------------------------------------
  // read path, two stages so every output leaves a flop
  // ------------------------------------------------------------
  always_comb begin
    rd_s1_d = acc_valid_in && !acc_write_in;
    ram_s1_d = tgt == banked_pkg::TGT_RAM;
    reg_s1_d = `DATA_ZERO;
    if (tgt == banked_pkg::TGT_PCL) begin
      reg_s1_d = pc_q[7:0];
    end else if (tgt == banked_pkg::TGT_STATUS) begin
      reg_s1_d = status_q;
    end else if (tgt == banked_pkg::TGT_FSR) begin
      reg_s1_d = fsr_q;
    end else if (tgt == banked_pkg::TGT_PROGRAM_COUNTER_UPPER_LATCH) begin
      reg_s1_d = program_counter_upper_latch_q;
    end
    rvalid_d = rd_s1_q;
    rdata_d = `DATA_ZERO;
    if (rd_s1_q) begin
      rdata_d = ram_s1_q ? ram.rdata : reg_s1_q;
    end
  end
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rd_s1_q <= 1'b0;
      ram_s1_q <= 1'b0;
      reg_s1_q <= `DATA_ZERO;
      rdata_q <= `DATA_ZERO;
      rvalid_q <= 1'b0;
    end else begin
      rd_s1_q <= rd_s1_d;
      ram_s1_q <= ram_s1_d;
      reg_s1_q <= reg_s1_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end
  assign prog_addr_out = pc_q;
  assign rdata_out = rdata_q;
  assign rvalid_out = rvalid_q;
  assign bank_out = status_q[`STATUS_BANK_HI:`STATUS_BANK_LO];
  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence s_read_req;
    acc_valid_in && !acc_write_in;
  endsequence
  sequence s_answer;
    ##2 rvalid_out;
  endsequence
  property p_irq_vec;
    @(posedge clk_in) disable iff (!rstn_in) irq_take_in |=> prog_addr_out == 13'h0004;
  endproperty
  a_irq_vec: assert property (p_irq_vec) else $error("interrupt entry not 0004h");
  property p_small_wrap;
    @(posedge clk_in) disable iff (!rstn_in) !LARGE_PROG |-> !prog_addr_out[12];
  endproperty
  a_small_wrap: assert property (p_small_wrap) else $error("small variant left 4K");
  property p_advance;
    @(posedge clk_in) disable iff (!rstn_in)
      pc_advance_in && !pc_jump_in && !irq_take_in && !wr && LARGE_PROG |=>
        prog_addr_out == $past(prog_addr_out) + 13'h0001;
  endproperty
  a_advance: assert property (p_advance) else $error("counter did not step");
  property p_read_latency;
    @(posedge clk_in) disable iff (!rstn_in) s_read_req |-> s_answer;
  endproperty
  a_read_latency: assert property (p_read_latency) else $error("read answer not two cycles later");
  property p_unmapped_zero;
    @(posedge clk_in) disable iff (!rstn_in)
      acc_valid_in && !acc_write_in && tgt == banked_pkg::TGT_NONE |-> ##2 rdata_out == 8'h00;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unimplemented read not zero");
  property p_fsr_mirror;
    @(posedge clk_in) disable iff (!rstn_in)
      wr && off == `OFF_FSR && acc_offset_in != `OFF_INDIRECT |=> fsr_q == $past(acc_wdata_in);
  endproperty
  a_fsr_mirror: assert property (p_fsr_mirror) else $error("pointer copy missed");
  property p_bank_sel;
    @(posedge clk_in) disable iff (!rstn_in)
      acc_offset_in != `OFF_INDIRECT |-> addr[8:7] == status_q[6:5];
  endproperty
  a_bank_sel: assert property (p_bank_sel) else $error("bank bits misplaced");
  property p_common;
    @(posedge clk_in) disable iff (!rstn_in) off >= 7'h70 |-> ram.addr == {2'b00, off - 7'h20};
  endproperty
  a_common: assert property (p_common) else $error("common area not bank 0");
  property p_indirect;
    @(posedge clk_in) disable iff (!rstn_in)
      acc_offset_in == 7'h00 |-> addr == {status_q[7], fsr_q};
  endproperty
  a_indirect: assert property (p_indirect) else $error("indirect not through pointer");
  property p_ram_range;
    @(posedge clk_in) disable iff (!rstn_in) ram.en |-> ram.addr < 9'(`RAM_DEPTH);
  endproperty
  a_ram_range: assert property (p_ram_range) else $error("ram index out of range");
endmodule : banked_memory_map_decoder
`default_nettype wire

// *** tb/core_model.sv ***
// core side model: issues one data access at a time
// assumes calls start just after a rising edge of clk_in
`timescale 1ns/10ps
`default_nettype none
module core_model (
  input wire logic clk_in,
  input wire logic [7:0] rdata_in,
  input wire logic rvalid_in,
  output logic acc_valid_out,
  output logic acc_write_out,
  output logic [6:0] acc_offset_out,
  output logic [7:0] acc_wdata_out
);
  initial begin
    acc_valid_out = 1'b0;
    acc_write_out = 1'b0;
    acc_offset_out = 7'h55;
    acc_wdata_out = 8'hAA;
  end
  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  // released lines flip so a stale value never passes
  task automatic drop();
    @(posedge clk_in);
    #1;
    acc_valid_out = 1'b0;
    acc_offset_out = ~acc_offset_out;
    acc_wdata_out = ~acc_wdata_out;
  endtask : drop
  // one idle edge before each call, so no line is set twice in a time step
  task automatic wr(input logic [6:0] off, input logic [7:0] d);
    @(posedge clk_in);
    #1;
    acc_valid_out = 1'b1;
    acc_write_out = 1'b1;
    acc_offset_out = off;
    acc_wdata_out = d;
    drop();
  endtask : wr
  task automatic rd(input logic [6:0] off, output logic [7:0] d, output bit ok);
    int i;
    @(posedge clk_in);
    #1;
    acc_valid_out = 1'b1;
    acc_write_out = 1'b0;
    acc_offset_out = off;
    drop();
    ok = 1'b0;
    d = 8'h00;
    for (i = 0; i < 4 && !ok; i++) begin
      @(posedge clk_in);
      #1;
      if (rvalid_in === 1'b1) begin
        ok = 1'b1;
        d = rdata_in;
      end
    end
  endtask : rd
endmodule : core_model
`default_nettype wire

// *** tb/banked_memory_map_decoder_tb_top.sv ***
// bench for the banked decoder: pc control plus data accesses via core_model
// assumes the large program and full ram variant
`timescale 1ns/10ps
`default_nettype none
module banked_memory_map_decoder_tb_top;
  logic clk, rstn, pc_adv, pc_jmp, irq, acc_valid, acc_write, rvalid;
  logic [10:0] jmp_addr;
  logic [6:0] acc_offset;
  logic [7:0] acc_wdata, rdata;
  logic [12:0] prog_addr;
  logic [1:0] bank;
  logic [12:0] prog_addr_small;
  logic [7:0] rdata_small;
  logic rvalid_small;
  logic [1:0] bank_small;
  int bad_count, checks;
  banked_memory_map_decoder #(.LARGE_PROG(1'b1), .BANK3_RAM(1'b1)) dut (
    .clk_in(clk), .rstn_in(rstn), .pc_advance_in(pc_adv), .pc_jump_in(pc_jmp),
    .pc_jump_addr_in(jmp_addr), .irq_take_in(irq), .acc_valid_in(acc_valid),
    .acc_write_in(acc_write), .acc_offset_in(acc_offset), .acc_wdata_in(acc_wdata),
    .prog_addr_out(prog_addr), .rdata_out(rdata), .rvalid_out(rvalid), .bank_out(bank));
  core_model m (.clk_in(clk), .rdata_in(rdata), .rvalid_in(rvalid), .acc_valid_out(acc_valid),
    .acc_write_out(acc_write), .acc_offset_out(acc_offset), .acc_wdata_out(acc_wdata));
  // small program, 256-byte variant shadows the same stimulus
  banked_memory_map_decoder #(.LARGE_PROG(1'b0), .BANK3_RAM(1'b0)) dut_small (
    .clk_in(clk), .rstn_in(rstn), .pc_advance_in(pc_adv), .pc_jump_in(pc_jmp),
    .pc_jump_addr_in(jmp_addr), .irq_take_in(irq), .acc_valid_in(acc_valid),
    .acc_write_in(acc_write), .acc_offset_in(acc_offset), .acc_wdata_in(acc_wdata),
    .prog_addr_out(prog_addr_small), .rdata_out(rdata_small), .rvalid_out(rvalid_small),
    .bank_out(bank_small));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : close_out
  task automatic chk(input string what, input logic [12:0] exp, input logic [12:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // a missing answer ends the run at once
  task automatic rchk(input string what, input logic [6:0] off, input logic [7:0] exp);
    logic [7:0] d;
    bit ok;
    m.rd(off, d, ok);
    if (!ok) begin
      bad_count++;
      $display("FAIL %s expected answer seen none", what);
      close_out();
    end
    chk(what, {5'h00, exp}, {5'h00, d});
  endtask : rchk
  task automatic sel(input logic [1:0] b);
    m.wr(7'h03, {1'b0, b, 5'h00});
  endtask : sel
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(posedge clk);
    #1;
    s = 1'b0;
  endtask : pulse
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rstn = 1'b0;
    pc_adv = 1'b0;
    pc_jmp = 1'b0;
    irq = 1'b0;
    jmp_addr = 11'h000;
    repeat (20) @(posedge clk);
    #1;
    rstn = 1'b1;
    chk("pc after reset", 13'h0000, prog_addr);
    chk("bank after reset", 13'h0000, {11'h000, bank});
    rchk("status reset", 7'h03, 8'h00);
    $display("test reset done");
    pc_adv = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk("pc advance", 13'h0003, prog_addr);
    pulse(irq); // irq wins over advance held high
    pc_adv = 1'b0;
    chk("pc irq", 13'h0004, prog_addr);
    m.wr(7'h0A, 8'h18);
    jmp_addr = 11'h7FF;
    pulse(pc_jmp);
    chk("pc jump top", 13'h1FFF, prog_addr);
    chk("small pc jump top", 13'h0FFF, prog_addr_small);
    pulse(pc_adv);
    chk("pc wrap", 13'h0000, prog_addr);
    chk("small pc wrap", 13'h0000, prog_addr_small);
    m.wr(7'h0A, 8'h0A);
    m.wr(7'h02, 8'h34);
    chk("pc pcl write", 13'h0A34, prog_addr);
    rchk("pcl read", 7'h02, 8'h34);
    $display("test program counter done");
    for (int b = 0; b < 4; b++) begin
      sel(2'(b));
      chk("bank select", 13'(b), {11'h000, bank});
      chk("small bank select", 13'(b), {11'h000, bank_small});
      m.wr(7'h20, 8'h10 + 8'(b));
    end
    for (int b = 0; b < 4; b++) begin
      sel(2'(b));
      rchk("bank ram", 7'h20, 8'h10 + 8'(b));
      chk("small rvalid", 13'h0001, {12'h000, rvalid_small});
      chk("small bank ram", {5'h00, (b == 3) ? 8'h00 : 8'h10 + 8'(b)}, {5'h00, rdata_small});
    end
    m.wr(7'h7F, 8'hC3);
    sel(2'd0);
    rchk("common area", 7'h7F, 8'hC3);
    $display("test banks done");
    sel(2'd1);
    m.wr(7'h04, 8'hA0);
    sel(2'd3);
    rchk("fsr mirror", 7'h04, 8'hA0);
    rchk("status mirror", 7'h03, 8'h60);
    m.wr(7'h00, 8'h5C);
    sel(2'd1);
    rchk("indirect write", 7'h20, 8'h5C);
    m.wr(7'h04, 8'h20);
    rchk("indirect read", 7'h00, 8'h10);
    m.wr(7'h04, 8'h00);
    rchk("indirect self", 7'h00, 8'h00);
    m.wr(7'h05, 8'hFF);
    rchk("unimplemented", 7'h05, 8'h00);
    m.wr(7'h03, 8'h80);
    m.wr(7'h04, 8'h20);
    rchk("indirect upper", 7'h00, 8'h12);
    $display("test indirect and unimplemented done");
    close_out();
  end
endmodule : banked_memory_map_decoder_tb_top
`default_nettype wire
